// ===== verilog/psi_pkg.sv
/*
 constants, indices and state codes for the power sequencer and interrupt logic.
 assumes a 125 MHz system clock and analog comparator levels arriving asynchronously.
*/
package psi_pkg;
   localparam int N_REG     = 4;
   localparam int N_CH      = 6;
   localparam int N_ASY     = 19;
   localparam int N_FLG     = 19;
   localparam int DLY_W     = 4;
   localparam int SD_CODE_W = 8;
   localparam int LR_CODE_W = 5;
   localparam int CNT_W     = 18;
   // flag bit positions
   localparam int F_SD_OC   = 0;
   localparam int F_LR_OC   = 2;
   localparam int F_SD_SC   = 4;
   localparam int F_LR_SC   = 6;
   localparam int F_HOT_W   = 8;
   localparam int F_HOT_SD  = 9;
   localparam int F_OVP     = 10;
   localparam int F_PG      = 11;
   localparam int F_GPIN    = 15;
   localparam int F_SYNC    = 16;
   localparam int F_MEAS    = 17;
   localparam int F_RST     = 18;
   // asynchronous input bit positions
   localparam int A_OC      = 0;
   localparam int A_LOW     = 4;
   localparam int A_VALID   = 8;
   localparam int A_HOT_W   = 12;
   localparam int A_HOT_SD  = 13;
   localparam int A_OVP     = 14;
   localparam int A_GPIN    = 15;
   localparam int A_SYNC    = 16;
   localparam int A_UVLO    = 17;
   localparam int A_EN      = 18;
   // reset values
   localparam logic [N_FLG-1:0] FLG_RST = 19'h00000;
   localparam logic [N_ASY-1:0] ASY_RST = 19'h20000;
   // timing
   localparam int CLK_MHZ     = 125;
   localparam int SC_TIME_US  = 1000;
   localparam int OTP_LOAD_US = 1200;
   localparam int DLY_STEP_US = 1000;
   localparam int SC_CYC      = SC_TIME_US * CLK_MHZ;
   localparam int OTP_CYC     = OTP_LOAD_US * CLK_MHZ;
   localparam int STEP_CYC    = DLY_STEP_US * CLK_MHZ;
   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_LOAD = 3'b010,
      ST_RUN  = 3'b100
   } psi_state_t;
endpackage : psi_pkg

// ===== verilog/psi_seq_ch.sv
/*
 one sequenced output channel: register or enable-pin control with rise and fall delays.
 assumes synchronised pin level, one-cycle edge and tick strobes and a kill level from the top.
*/
`timescale 1ns/10ps
module psi_seq_ch (
   // clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_nrst,
   // control bits
   input  wire logic                    i_on_bit,
   input  wire logic                    i_pin_control,
   input  wire logic [psi_pkg::DLY_W-1:0] i_rise_delay,
   input  wire logic [psi_pkg::DLY_W-1:0] i_fall_delay,
   // pin and timing strobes
   input  wire logic                    i_pin,
   input  wire logic                    i_rise,
   input  wire logic                    i_fall,
   input  wire logic                    i_tick,
   input  wire logic                    i_kill,
   // result
   output logic                         o_on
);
   import psi_pkg::*;
   logic             on_r;
   logic             pend_r;
   logic [DLY_W-1:0] cnt_r;
   logic             on_nxt;
   logic             pend_nxt;
   logic [DLY_W-1:0] cnt_nxt;
   wire              pin_mode = i_on_bit & i_pin_control;
   wire              edge_s   = i_rise | i_fall;
   wire [DLY_W-1:0]  dly      = i_rise ? i_rise_delay : i_fall_delay;
   wire              load     = edge_s & (i_pin != on_r) & (dly != 4'h0);
   wire              now_s    = edge_s & (dly == 4'h0);
   wire              done     = pend_r & i_tick & (cnt_r == 4'h1);

   // register mode tracks the pin so a switch to pin mode starts consistent
   assign on_nxt   = i_kill ? 1'b0 :
                     (~pin_mode | now_s | done) ? i_pin : on_r;
   // any new edge replaces a waiting transition
   assign pend_nxt = i_kill ? 1'b0 : load ? 1'b1 :
                     (edge_s | done) ? 1'b0 : pend_r;
   assign cnt_nxt  = load ? dly :
                     (pend_r & i_tick) ? cnt_r - 4'h1 : cnt_r;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         on_r   <= 1'b0;
         pend_r <= 1'b0;
         cnt_r  <= 4'h0;
      end else begin
         on_r   <= on_nxt;
         pend_r <= pend_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   assign o_on = i_on_bit & ~i_kill & (i_pin_control ? on_r : 1'b1);
endmodule : psi_seq_ch

// ===== verilog/psi_power_seq.sv
/*
 power sequencer, reset control and interrupt flags of a multi-rail power device.
 assumes control bits come from a serial register file on the same clock and
 comparator levels and the enable pin arrive asynchronously.
*/
`timescale 1ns/10ps
module psi_power_seq #(
   parameter int SC_CYC_P   = psi_pkg::SC_CYC,
   parameter int OTP_CYC_P  = psi_pkg::OTP_CYC,
   parameter int STEP_CYC_P = psi_pkg::STEP_CYC
) (
   // clock and reset
   input  wire logic                                 i_clk_sys,
   input  wire logic                                 i_nrst,
   // pins and analog comparators
   input  wire logic                                 i_seq_enable_pin,
   input  wire logic                                 i_analog_supply_low,
   input  wire logic [psi_pkg::N_REG-1:0]            i_overcurrent,
   input  wire logic [psi_pkg::N_REG-1:0]            i_out_below_short,
   input  wire logic [psi_pkg::N_REG-1:0]            i_out_valid,
   input  wire logic                                 i_hot_warning,
   input  wire logic                                 i_hot_shutdown,
   input  wire logic                                 i_supply_overvoltage,
   input  wire logic                                 i_good_pin_valid,
   input  wire logic                                 i_sync_clk_present,
   // step-down control
   input  wire logic [1:0]                           i_step_down_on_bit,
   input  wire logic [1:0]                           i_step_down_pin_control,
   input  wire logic [1:0][psi_pkg::SD_CODE_W-1:0]   i_step_down_voltage_code,
   input  wire logic [1:0][psi_pkg::DLY_W-1:0]       i_step_down_rise_delay,
   input  wire logic [1:0][psi_pkg::DLY_W-1:0]       i_step_down_fall_delay,
   // linear regulator control
   input  wire logic [1:0]                           i_linear_reg_on_bit,
   input  wire logic [1:0]                           i_linear_reg_pin_control,
   input  wire logic [1:0][psi_pkg::LR_CODE_W-1:0]   i_linear_reg_voltage_code,
   input  wire logic [1:0][psi_pkg::DLY_W-1:0]       i_linear_reg_rise_delay,
   input  wire logic [1:0][psi_pkg::DLY_W-1:0]       i_linear_reg_fall_delay,
   // aux output control
   input  wire logic [1:0]                           i_aux_out_on_bit,
   input  wire logic [1:0]                           i_aux_out_pin_control,
   input  wire logic [1:0][psi_pkg::DLY_W-1:0]       i_aux_out_rise_delay,
   input  wire logic [1:0][psi_pkg::DLY_W-1:0]       i_aux_out_fall_delay,
   // reset and interrupt control
   input  wire logic                                 i_soft_reset_trigger,
   input  wire logic                                 i_otp_reset_mask,
   input  wire logic                                 i_good_pin_polarity,
   input  wire logic                                 i_clk_detect_en,
   input  wire logic                                 i_load_meas_done,
   input  wire logic [psi_pkg::N_FLG-1:0]            i_flag_mask,
   input  wire logic [psi_pkg::N_REG-1:0]            i_good_fall_mask,
   input  wire logic [psi_pkg::N_FLG-1:0]            i_flag_clear,
   // regulator and aux outputs
   output logic [1:0]                                o_step_down_en,
   output logic [1:0][psi_pkg::SD_CODE_W-1:0]        o_step_down_target,
   output logic [1:0]                                o_linear_reg_en,
   output logic [1:0][psi_pkg::LR_CODE_W-1:0]        o_linear_reg_target,
   output logic [1:0]                                o_aux_out,
   output logic                                      o_good_pin_level,
   // reset status
   output logic                                      o_soft_reset_trigger,
   output logic                                      o_defaults_load,
   output logic                                      o_otp_load,
   // flags and status
   output logic [psi_pkg::N_FLG-1:0]                 o_flags,
   output logic [psi_pkg::N_REG-1:0]                 o_overcurrent_stat,
   output logic [psi_pkg::N_REG-1:0]                 o_good_stat,
   output logic                                      o_hot_warning_stat,
   output logic                                      o_hot_shutdown_stat,
   output logic                                      o_overvoltage_stat,
   output logic                                      o_good_pin_stat,
   output logic                                      o_sync_clk_stat,
   output logic                                      o_irq_pin_active_low
);
   import psi_pkg::*;

   localparam logic [CNT_W-1:0] SC_LAST   = CNT_W'(SC_CYC_P - 1);
   localparam logic [CNT_W-1:0] OTP_LAST  = CNT_W'(OTP_CYC_P - 1);
   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC_P - 1);

   // input synchroniser
   logic [N_ASY-1:0] sy1_r;
   logic [N_ASY-1:0] sy2_r;
   logic [N_ASY-1:0] sy3_r;
   wire  [N_ASY-1:0] asy_in = {i_seq_enable_pin, i_analog_supply_low,
                               i_sync_clk_present, i_good_pin_valid,
                               i_supply_overvoltage, i_hot_shutdown, i_hot_warning,
                               i_out_valid, i_out_below_short, i_overcurrent};
   wire  [N_ASY-1:0] asy_rise = sy2_r & ~sy3_r;
   wire  [N_ASY-1:0] asy_fall = ~sy2_r & sy3_r;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         sy1_r <= ASY_RST;
         sy2_r <= ASY_RST;
         sy3_r <= ASY_RST;
      end else begin
         sy1_r <= asy_in;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
      end
   end

   wire              uvlo    = sy2_r[A_UVLO];
   wire              pin     = sy2_r[A_EN];
   wire [N_REG-1:0]  oc_lvl  = sy2_r[A_OC +: N_REG];
   wire [N_REG-1:0]  low_lvl = sy2_r[A_LOW +: N_REG];
   wire [N_REG-1:0]  v_lvl   = sy2_r[A_VALID +: N_REG];
   wire [N_REG-1:0]  v_rise  = asy_rise[A_VALID +: N_REG];
   wire [N_REG-1:0]  v_fall  = asy_fall[A_VALID +: N_REG];

   // reset sequence
   psi_state_t       state_r;
   psi_state_t       state_nxt;
   logic [CNT_W-1:0] ld_cnt_r;
   logic             cause_r;
   logic             otp_mask_r;
   logic             soft_rst_r;
   logic             run_q_r;

   wire run       = (state_r == ST_RUN);
   wire loading   = (state_r == ST_LOAD);
   wire ld_done   = loading & (ld_cnt_r == OTP_LAST);
   wire run_enter = loading & (state_nxt == ST_RUN);
   wire run_start = run & ~run_q_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (!uvlo) state_nxt = ST_LOAD;
         end
         ST_LOAD: begin
            if (ld_done) state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (soft_rst_r) state_nxt = ST_LOAD;
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
      if (uvlo) state_nxt = ST_OFF;
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r    <= ST_LOAD;
         ld_cnt_r   <= 18'h00000;
         cause_r    <= 1'b1;
         otp_mask_r <= 1'b0;
         soft_rst_r <= 1'b0;
         run_q_r    <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         ld_cnt_r   <= loading ? ld_cnt_r + 18'h00001 : 18'h00000;
         cause_r    <= (uvlo | soft_rst_r) | (cause_r & ~run_enter);
         otp_mask_r <= loading ? i_otp_reset_mask : otp_mask_r;
         soft_rst_r <= i_soft_reset_trigger & run;
         run_q_r    <= run;
      end
   end

   // global kill: not running, hot shutdown or overvoltage
   wire glob_kill = ~run | sy2_r[A_HOT_SD] | sy2_r[A_OVP];

   // delay time base, restarted on every pin edge
   logic [CNT_W-1:0] step_cnt_r;
   wire              pin_rise = asy_rise[A_EN] | (pin & run_start);
   wire              pin_fall = asy_fall[A_EN];
   wire              restart  = pin_rise | pin_fall;
   wire              tick     = (step_cnt_r == STEP_LAST);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         step_cnt_r <= 18'h00000;
      end else begin
         step_cnt_r <= (restart | tick) ? 18'h00000 : step_cnt_r + 18'h00001;
      end
   end

   // sequencer channels: 0-1 step-down, 2-3 linear, 4-5 aux
   wire [N_CH-1:0]       ch_on_bit = {i_aux_out_on_bit, i_linear_reg_on_bit,
                                      i_step_down_on_bit};
   wire [N_CH-1:0]       ch_pinctl = {i_aux_out_pin_control, i_linear_reg_pin_control,
                                      i_step_down_pin_control};
   wire [N_CH*DLY_W-1:0] ch_rise_d = {i_aux_out_rise_delay, i_linear_reg_rise_delay,
                                      i_step_down_rise_delay};
   wire [N_CH*DLY_W-1:0] ch_fall_d = {i_aux_out_fall_delay, i_linear_reg_fall_delay,
                                      i_step_down_fall_delay};
   logic [N_CH-1:0]      ch_on;

   genvar c;
   generate
      for (c = 0; c < N_CH; c++) begin : g_ch
         psi_seq_ch u_seq (
            .i_clk_sys     (i_clk_sys),
            .i_nrst        (i_nrst),
            .i_on_bit      (ch_on_bit[c]),
            .i_pin_control (ch_pinctl[c]),
            .i_rise_delay  (ch_rise_d[c*DLY_W +: DLY_W]),
            .i_fall_delay  (ch_fall_d[c*DLY_W +: DLY_W]),
            .i_pin         (pin),
            .i_rise        (pin_rise),
            .i_fall        (pin_fall),
            .i_tick        (tick),
            .i_kill        (glob_kill),
            .o_on          (ch_on[c])
         );
      end
   endgenerate

   // short-circuit detection per regulator
   logic [N_REG-1:0] sc_off_r;
   logic [N_REG-1:0] sc_hit;
   logic [N_REG-1:0] reg_en;

   genvar r;
   generate
      for (r = 0; r < N_REG; r++) begin : g_sc
         logic [CNT_W-1:0] sc_cnt_r;
         assign reg_en[r] = ch_on[r] & ~sc_off_r[r];
         assign sc_hit[r] = reg_en[r] & low_lvl[r] & (sc_cnt_r == SC_LAST);
         always_ff @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               sc_cnt_r    <= 18'h00000;
               sc_off_r[r] <= 1'b0;
            end else begin
               sc_cnt_r    <= (reg_en[r] & low_lvl[r] & ~sc_hit[r]) ?
                              sc_cnt_r + 18'h00001 : 18'h00000;
               sc_off_r[r] <= sc_hit[r] | (sc_off_r[r] & ch_on[r]);
            end
         end
      end
   endgenerate

   // flag set events
   wire [N_FLG-1:0] flg_set;
   logic [N_FLG-1:0] flag_r;
   wire sync_evt = asy_rise[A_SYNC] | asy_fall[A_SYNC] |
                   (i_clk_detect_en & ~sy2_r[A_SYNC]);

   assign flg_set[F_SD_OC +: 4] = oc_lvl & ~i_flag_mask[F_SD_OC +: 4];
   assign flg_set[F_SD_SC +: 4] = sc_hit;
   assign flg_set[F_HOT_W]      = sy2_r[A_HOT_W] & ~i_flag_mask[F_HOT_W];
   assign flg_set[F_HOT_SD]     = sy2_r[A_HOT_SD];
   assign flg_set[F_OVP]        = sy2_r[A_OVP];
   assign flg_set[F_PG +: 4]    = (v_rise & ~i_flag_mask[F_PG +: 4]) |
                                  (v_fall & ~i_good_fall_mask);
   assign flg_set[F_GPIN]       = asy_fall[A_GPIN] & ~i_flag_mask[F_GPIN];
   assign flg_set[F_SYNC]       = sync_evt & ~i_flag_mask[F_SYNC];
   assign flg_set[F_MEAS]       = i_load_meas_done & ~i_flag_mask[F_MEAS];
   assign flg_set[F_RST]        = run_enter & cause_r & ~otp_mask_r;

   // sticky flags: set wins over clear, all cleared outside run
   genvar f;
   generate
      for (f = 0; f < N_FLG; f++) begin : g_flg
         always_ff @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               flag_r[f] <= FLG_RST[f];
            end else begin
               flag_r[f] <= flg_set[f] | (flag_r[f] & ~i_flag_clear[f] & run);
            end
         end
      end
   endgenerate

   // output registers
   logic             irq_n_r;
   logic [N_REG-1:0] en_r;
   logic [1:0]       aux_r;
   logic             gpin_r;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_n_r             <= 1'b1;
         en_r                <= 4'h0;
         aux_r               <= 2'h0;
         gpin_r              <= 1'b0;
         o_step_down_target  <= '0;
         o_linear_reg_target <= '0;
      end else begin
         irq_n_r <= ~|flag_r;
         en_r    <= reg_en;
         aux_r   <= ch_on[5:4];
         gpin_r  <= i_good_pin_polarity ? sy2_r[A_GPIN] : ~sy2_r[A_GPIN];
         o_step_down_target[0]  <= reg_en[0] ? i_step_down_voltage_code[0] : 8'h00;
         o_step_down_target[1]  <= reg_en[1] ? i_step_down_voltage_code[1] : 8'h00;
         o_linear_reg_target[0] <= reg_en[2] ? i_linear_reg_voltage_code[0] : 5'h00;
         o_linear_reg_target[1] <= reg_en[3] ? i_linear_reg_voltage_code[1] : 5'h00;
      end
   end

   assign o_step_down_en       = en_r[1:0];
   assign o_linear_reg_en      = en_r[3:2];
   assign o_aux_out            = aux_r;
   assign o_good_pin_level     = gpin_r;
   assign o_soft_reset_trigger = soft_rst_r;
   assign o_defaults_load      = ~run;
   assign o_otp_load           = loading;
   assign o_flags              = flag_r;
   assign o_overcurrent_stat   = oc_lvl;
   assign o_good_stat          = v_lvl;
   assign o_hot_warning_stat   = sy2_r[A_HOT_W];
   assign o_hot_shutdown_stat  = sy2_r[A_HOT_SD];
   assign o_overvoltage_stat   = sy2_r[A_OVP];
   assign o_good_pin_stat      = sy2_r[A_GPIN];
   assign o_sync_clk_stat      = sy2_r[A_SYNC];
   assign o_irq_pin_active_low = irq_n_r;
endmodule : psi_power_seq

// ===== dv/psi_power_seq_chk.sv
/* assertions on the sequencer top ports.
   assumes a bind into psi_power_seq and one clock domain. */
`timescale 1ns/10ps
module psi_power_seq_chk (
   // clock and reset
   input wire logic                      i_clk_sys,
   input wire logic                      i_nrst,
   // inputs
   input wire logic                      i_analog_supply_low,
   input wire logic                      i_hot_shutdown,
   input wire logic                      i_supply_overvoltage,
   input wire logic                      i_load_meas_done,
   input wire logic [psi_pkg::N_FLG-1:0] i_flag_mask,
   // outputs
   input wire logic [1:0]                o_step_down_en,
   input wire logic [1:0]                o_linear_reg_en,
   input wire logic [1:0]                o_aux_out,
   input wire logic                      o_soft_reset_trigger,
   input wire logic                      o_defaults_load,
   input wire logic [psi_pkg::N_FLG-1:0] o_flags,
   input wire logic [3:0]                o_overcurrent_stat,
   input wire logic                      o_hot_shutdown_stat,
   input wire logic                      o_irq_pin_active_low
);
   import psi_pkg::*;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   sequence s_dark;
      o_step_down_en == 2'h0 && o_linear_reg_en == 2'h0 && o_aux_out == 2'h0;
   endsequence
   irq_follow_a: assert property (o_irq_pin_active_low == ($past(o_flags) == '0))
      else $error("irq pin wrong");
   sr_clear_a: assert property (o_soft_reset_trigger |=> !o_soft_reset_trigger)
      else $error("soft reset bit stuck");
   sr_dark_a: assert property (o_soft_reset_trigger |-> ##2 s_dark)
      else $error("outputs live after soft reset");
   uv_dark_a: assert property (i_analog_supply_low [*8] |-> s_dark)
      else $error("outputs live in undervoltage");
   kill_dark_a: assert property ((i_hot_shutdown || i_supply_overvoltage) [*6] |-> s_dark)
      else $error("outputs live in fault");
   hot_flag_a: assert property (o_hot_shutdown_stat && !o_defaults_load |=> o_flags[F_HOT_SD])
      else $error("hot flag missing");
   meas_set_a: assert property (i_load_meas_done && !i_flag_mask[F_MEAS] && !o_defaults_load
      |=> o_flags[F_MEAS]) else $error("meas flag missing");
   oc_flag_a: assert property (o_overcurrent_stat[0] && !i_flag_mask[F_SD_OC] && !o_defaults_load
      |=> o_flags[F_SD_OC]) else $error("overcurrent flag missing");
endmodule : psi_power_seq_chk
bind psi_power_seq psi_power_seq_chk chk (.*);

// ===== dv/psi_host_model.sv
/* host model: drives the sequence enable pin and the soft reset strobe.
   assumes the bench clock; changes follow a rising edge by 1 ns. */
`timescale 1ns/10ps
module psi_host_model (
   // clock
   input  wire logic i_clk_sys,
   // pin and strobe
   output logic      o_enable_pin,
   output logic      o_soft_reset
);
   initial begin
      o_enable_pin = 1'b0;
      o_soft_reset = 1'b0;
   end
   task automatic drive_pin(input logic v);
      @(posedge i_clk_sys);
      #1 o_enable_pin = v;
   endtask : drive_pin
   task automatic soft_reset();
      @(posedge i_clk_sys);
      #1 o_soft_reset = 1'b1;
      @(posedge i_clk_sys);
      #1 o_soft_reset = 1'b0;
   endtask : soft_reset
endmodule : psi_host_model

// ===== dv/tb_top.sv
/* bench for psi_power_seq with a host model on the enable pin.
   assumes short time-base parameters: step 8, load 10, short 20 cycles. */
`timescale 1ns/10ps
module tb_top;
   import psi_pkg::*;
   logic i_clk_sys = 0, i_nrst = 0, i_seq_enable_pin, i_soft_reset_trigger, i_hot_warning = 0;
   logic i_analog_supply_low = 0, i_hot_shutdown = 0, i_supply_overvoltage = 0;
   logic i_good_pin_valid, i_good_pin_polarity, i_load_meas_done = 0, i_otp_reset_mask = 0;
   logic [3:0] i_overcurrent = 0, i_out_below_short = 0, i_out_valid;
   logic [3:0] o_overcurrent_stat, o_good_stat;
   logic [1:0] i_step_down_on_bit, i_step_down_pin_control, i_linear_reg_on_bit;
   logic [1:0] i_linear_reg_pin_control, i_aux_out_on_bit, i_aux_out_pin_control;
   logic [1:0][7:0] i_step_down_voltage_code, o_step_down_target;
   logic [1:0][4:0] i_linear_reg_voltage_code, o_linear_reg_target;
   logic [1:0][3:0] i_step_down_rise_delay, i_step_down_fall_delay, i_linear_reg_rise_delay;
   logic [1:0][3:0] i_linear_reg_fall_delay, i_aux_out_rise_delay, i_aux_out_fall_delay;
   logic [N_FLG-1:0] i_flag_mask, i_flag_clear = 0, o_flags;
   logic [1:0] o_step_down_en, o_linear_reg_en, o_aux_out;
   logic o_good_pin_level, o_soft_reset_trigger, o_defaults_load, o_otp_load;
   logic o_hot_warning_stat, o_hot_shutdown_stat, o_overvoltage_stat, o_good_pin_stat;
   logic o_sync_clk_stat, o_irq_pin_active_low;
   typedef struct {logic [5:0] v; int t;} psi_exp_t;
   psi_exp_t q[$];
   psi_exp_t e;
   logic [5:0] last = 6'h00;
   int n_fail = 0, check_count = 0, cyc = 0, d;
   wire [5:0] outv = {o_aux_out, o_linear_reg_en, o_step_down_en};
   psi_host_model host (.i_clk_sys, .o_enable_pin(i_seq_enable_pin),
      .o_soft_reset(i_soft_reset_trigger));
   psi_power_seq #(.SC_CYC_P(20), .OTP_CYC_P(10), .STEP_CYC_P(8)) dut (
      .i_good_fall_mask(4'hF), .i_clk_detect_en(1'b1), .i_sync_clk_present(1'b1), .*);
   initial forever #4 i_clk_sys = ~i_clk_sys;
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_t(input int got, exp);
      check_count++;
      if (got > exp + 2 || got < exp - 2) begin
         n_fail++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk_t
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : step
   task automatic set_ch(input logic [1:0] on, pc);
      {i_step_down_on_bit, i_linear_reg_on_bit, i_aux_out_on_bit} = {3{on}};
      {i_step_down_pin_control, i_linear_reg_pin_control, i_aux_out_pin_control} = {3{pc}};
   endtask : set_ch
   task automatic clear(input logic [N_FLG-1:0] v);
      i_flag_clear = v;
      step(1);
      i_flag_clear = '0;
      step(3);
   endtask : clear
   // watcher: each change of the enables takes the oldest note
   always @(posedge i_clk_sys) begin
      cyc++;
      if (i_nrst && outv !== last) begin
         e = q.size() ? q.pop_front() : '{~outv, -1};
         chk({26'h0, outv}, {26'h0, e.v});
         if (e.t >= 0) chk_t(cyc, e.t);
         last = outv;
      end
      if (cyc > 3000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      void'($urandom(2));
      {i_out_valid, i_good_pin_valid, i_good_pin_polarity} = 6'($urandom);
      i_step_down_voltage_code = 16'($urandom);
      i_linear_reg_voltage_code = 10'($urandom);
      i_flag_mask = 19'h5FFF0;
      for (int i = 0; i < 2; i++) begin
         {i_step_down_rise_delay[i], i_step_down_fall_delay[i]} = {4'(i + 1), 4'(6 - i)};
         {i_linear_reg_rise_delay[i], i_linear_reg_fall_delay[i]} = {4'(i + 3), 4'(4 - i)};
         {i_aux_out_rise_delay[i], i_aux_out_fall_delay[i]} = {4'(i + 5), 4'(2 - i)};
      end
      set_ch(2'h3, 2'h3);
      step(3);
      i_nrst = 1'b1;
      step(30);
      chk(o_flags, 19'h40000);
      chk({o_good_pin_level, o_good_pin_stat},
         {i_good_pin_polarity ~^ i_good_pin_valid, i_good_pin_valid});
      chk(o_good_stat, i_out_valid);
      clear(19'h7FFFF);
      host.drive_pin(1'b1);
      for (int k = 0; k < 6; k++) q.push_back('{6'((2 << k) - 1), cyc + 12 + 8 * k});
      step(70);
      host.drive_pin(1'b0);
      for (int k = 5; k >= 0; k--) q.push_back('{6'((1 << k) - 1), cyc + 52 - 8 * k});
      step(70);
      host.drive_pin(1'b1);
      step(3);
      host.drive_pin(1'b0);
      step(70);
      set_ch(2'h3, 2'h0);
      q.push_back('{6'h3F, cyc + 2});
      step(10);
      chk({o_step_down_target, o_linear_reg_target},
         {i_step_down_voltage_code, i_linear_reg_voltage_code});
      for (int k = 0; k < 3; k++) begin
         {i_supply_overvoltage, i_hot_shutdown, i_analog_supply_low} = 3'(1 << k);
         q.push_back('{6'h00, -1});
         step(20);
         {i_supply_overvoltage, i_hot_shutdown, i_analog_supply_low} = 3'h0;
         q.push_back('{6'h3F, -1});
         step(40);
      end
      chk(o_flags, 19'h40600);
      clear(19'h7FFFF);
      i_otp_reset_mask = 1'b1;
      host.soft_reset();
      q.push_back('{6'h00, -1});
      q.push_back('{6'h3F, -1});
      step(40);
      chk(o_flags, 19'h0);
      i_out_below_short = 4'h1;
      q.push_back('{6'h3E, -1});
      step(30);
      i_out_below_short = 4'h0;
      chk(o_flags, 19'h00010);
      clear(19'h00010);
      i_load_meas_done = 1'b1;
      step(1);
      i_load_meas_done = 1'b0;
      step(2);
      chk({o_irq_pin_active_low, o_flags}, {1'b0, 19'h20000});
      clear(19'h20000);
      chk({o_irq_pin_active_low, o_flags}, {1'b1, 19'h0});
      i_overcurrent = 4'h1 | 4'($urandom);
      i_hot_warning = 1'b1;
      i_flag_mask[F_HOT_W] = 1'b0;
      step(6);
      clear(19'h0010F);
      chk(o_flags, {10'h0, 1'b1, 4'h0, i_overcurrent});
      chk(o_hot_warning_stat, 1'b1);
      i_overcurrent = 4'h0;
      i_hot_warning = 1'b0;
      step(4);
      clear(19'h0010F);
      chk(o_flags, 19'h0);
      // pin mode with pin low drops all outputs and frees the short latch
      set_ch(2'h3, 2'h3);
      q.push_back('{6'h00, cyc + 2});
      d = $urandom;
      {i_step_down_rise_delay, i_linear_reg_rise_delay, i_aux_out_rise_delay} = {6{d[3:0]}};
      {i_step_down_fall_delay, i_linear_reg_fall_delay, i_aux_out_fall_delay} = {6{d[7:4]}};
      host.drive_pin(1'b1);
      q.push_back('{6'h3F, cyc + 4 + 8 * d[3:0]});
      step(130);
      host.drive_pin(1'b0);
      q.push_back('{6'h00, cyc + 4 + 8 * d[7:4]});
      step(130);
      chk(q.size(), 0);
      conclude();
   end
endmodule : tb_top
